// ==== testbench/deflection_i2c_sync_control_tb_top.sv ====
// Self-checking bench for the deflection serial control and sync block
`timescale 1ns/1ps
`default_nettype none
module deflection_i2c_sync_control_tb_top;
	logic ref_clk = 1'b0;
	logic syncClk = 1'b0;
	logic rst_n = 1'b0;
	logic vddOk = 1'b1;
	logic vccOk = 1'b1;
	logic xrayIn = 1'b0;
	logic hPllLocked = 1'b0;
	logic vLocked = 1'b0;
	logic horizSyncInput = 1'b1;
	logic vSyncIn = 1'b0;
	logic vSeen = 1'b0;
	logic sclLow, sdaLow, sclOut, sclOe, sdaOut, sdaOe, sclLine, sdaLine;
	logic hLockOut, hDriveEn, hSyncOut, vSyncOut;
	logic [dsc_pkg::NUM_ADJ-1:0][7:0] adjOut;
	logic [dsc_pkg::NUM_ADJ-1:0][7:0] expAdj;
	logic [7:0] aw;
	logic [31:0] seed = 32'h0000004a;
	int err_count = 0;
	int compares = 0;
	int hCount = 0;
	always #2.5 ref_clk = ~ref_clk;
	always #3 syncClk = ~syncClk;
	// Both lines have pull-ups, so a released line reads high
	assign sclLine = ~(sclLow | (sclOe & ~sclOut));
	assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
	always @(posedge ref_clk)
		if (vSyncOut === 1'b1)
			vSeen <= 1'b1;
	always @(posedge syncClk)
		if (hSyncOut === 1'b1)
			hCount <= hCount + 1;
	dsc_sync_ctrl #(.CNT_W(16)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .syncClk(syncClk), .sclIn(sclLine),
		.sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .vddOk(vddOk),
		.vccOk(vccOk), .xrayIn(xrayIn), .hPllLocked(hPllLocked), .vLocked(vLocked),
		.horizSyncInput(horizSyncInput), .vSyncIn(vSyncIn), .hLockOut(hLockOut), .hDriveEn(hDriveEn),
		.hSyncOut(hSyncOut), .vSyncOut(vSyncOut), .adjOut(adjOut));
	dsc_bus_master #(.QTR(125)) i_master (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	function automatic logic [7:0] expStat(input logic hl, input logic vl, input logic xr, input logic vp,
		input logic ve);
		return {~hl, ~vl, xr, 1'b1, vp, ve, 2'b00};
	endfunction : expStat
	task automatic close_out();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chkBit(input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t exp %h got %h", $time, exp, got);
		end
	endtask : chkBit
	task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk8
	task automatic chkAdj(input logic [dsc_pkg::NUM_ADJ-1:0][7:0] exp, input logic [dsc_pkg::NUM_ADJ-1:0][7:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t exp %h got %h", $time, exp, got);
		end
	endtask : chkAdj
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : idle
	task automatic send(input logic [7:0] q[$], input logic glitch);
		logic ack;
		i_master.busStart();
		foreach (q[i])
		begin
			i_master.writeByte(q[i], glitch && i == 0, ack);
			chkBit(1'b1, ack);
		end
		i_master.busStop();
		idle(20);
		chkBit(1'b0, sdaOe);
	endtask : send
	task automatic rdStat(input logic [7:0] exp);
		logic ack;
		logic [7:0] v;
		i_master.busStart();
		i_master.writeByte({dsc_pkg::DEV_ADDR, dsc_pkg::DIR_READ}, 1'b0, ack);
		chkBit(1'b1, ack);
		i_master.readByte(v);
		chk8(exp, v);
		i_master.busStop();
		idle(20);
		chkBit(1'b0, sdaOe);
	endtask : rdStat
	// Short high pulses on the separate vertical input; each rise is a retrace once a source is chosen
	task automatic vBurst();
		repeat (4)
		begin
			vSyncIn = 1'b1;
			idle(20);
			vSyncIn = 1'b0;
			idle(200);
		end
	endtask : vBurst
	// Negative line pulses, far under a quarter of their spacing
	task automatic hPulses(input int n, input int gap);
		repeat (n)
		begin
			horizSyncInput = 1'b0;
			idle(8);
			horizSyncInput = 1'b1;
			idle(gap - 8);
		end
	endtask : hPulses
	initial
	begin
		idle(120000);
		err_count++;
		close_out();
	end
	initial
	begin
		logic [7:0] d;
		logic [7:0] q[$];
		logic ack;
		expAdj = dsc_pkg::ADJ_RESET;
		aw = {dsc_pkg::DEV_ADDR, dsc_pkg::DIR_WRITE};
		idle(5);
		rst_n = 1'b1;
		idle(10);
		chkAdj(dsc_pkg::ADJ_RESET, adjOut);
		chkBit(1'b0, sdaOe);
		chkBit(1'b0, hLockOut);
		chkBit(1'b1, hDriveEn);
		// Vertical line held low reads as positive; horizontal keeps its negative initial value
		rdStat(expStat(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		vBurst();
		chkBit(1'b0, vSeen);
		seed = xs(seed);
		d = {seed[6:0] == dsc_pkg::DEV_ADDR ? ~seed[6:0] : seed[6:0], dsc_pkg::DIR_WRITE};
		i_master.busStart();
		i_master.writeByte(d, 1'b0, ack);
		chkBit(1'b0, ack);
		i_master.busStop();
		// Burst from the top subaddress so the counter wraps into the low bytes
		q = {aw, 8'h0f};
		for (int k = 0; k < 5; k++)
		begin
			seed = xs(seed);
			d = seed[7:0];
			if (k == 1)
				d[dsc_pkg::HDRIVE_BIT] = 1'b1;
			if (k == 2)
				d[dsc_pkg::XRAYRST_BIT] = 1'b0;
			if (k == 4)
				d[7:6] = dsc_pkg::PRIO_SEPARATE;
			expAdj[4'(15 + k)] = d;
			q.push_back(d);
		end
		send(q, 1'b1);
		idle(20);
		chkAdj(dsc_pkg::ADJ_RESET, adjOut);
		hPllLocked = 1'b1;
		vLocked = 1'b1;
		vSeen = 1'b0;
		vBurst();
		chkBit(1'b1, vSeen);
		chkAdj(expAdj, adjOut);
		chkBit(1'b1, hLockOut);
		chkBit(1'b1, hDriveEn);
		rdStat(expStat(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
		xrayIn = 1'b1;
		idle(20);
		xrayIn = 1'b0;
		idle(20);
		chkBit(1'b0, hDriveEn);
		q = {aw, 8'(dsc_pkg::SUB_REFRESH), 8'h80};
		send(q, 1'b0);
		rdStat(expStat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
		q = {aw, 8'(dsc_pkg::SUB_XRAY), 8'h80};
		send(q, 1'b0);
		vBurst();
		rdStat(expStat(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
		chkBit(1'b1, hDriveEn);
		// Six full lines, then pulses at half spacing: only every second one is a line
		hPulses(6, 100);
		hPulses(4, 50);
		idle(20);
		chk8(8'h08, 8'(hCount));
		vccOk = 1'b0;
		idle(10);
		chkBit(1'b0, hDriveEn);
		chkBit(1'b0, hLockOut);
		close_out();
	end
endmodule : deflection_i2c_sync_control_tb_top
`default_nettype wire

// ==== testbench/dsc_bus_master.sv ====
// Serial bus master model standing in for the monitor microcontroller
`timescale 1ns/1ps
`default_nettype none
module dsc_bus_master #(
	parameter int QTR = 125
) (
	input wire logic ref_clk,
	input wire logic sdaLine,
	output logic sclLow,
	output logic sdaLow
);
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	task automatic waitQ(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : waitQ
	task automatic busStart();
		sdaLow = 1'b1;
		waitQ(QTR);
		sclLow = 1'b1;
		waitQ(QTR);
	endtask : busStart
	// A glitch is a 30 ns spike on the clock line in mid low phase; a filter that misses it shifts the byte
	task automatic bitIo(input logic b, input logic glitch, output logic s);
		sdaLow = ~b;
		waitQ(QTR / 2);
		if (glitch)
		begin
			sclLow = 1'b0;
			waitQ(6);
			sclLow = 1'b1;
		end
		waitQ(QTR - QTR / 2);
		sclLow = 1'b0;
		waitQ(QTR);
		s = sdaLine;
		waitQ(QTR);
		sclLow = 1'b1;
		waitQ(QTR);
	endtask : bitIo
	task automatic writeByte(input logic [7:0] d, input logic glitch, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitIo(d[i], glitch && i == 4, s);
		bitIo(1'b1, 1'b0, s);
		ack = ~s;
	endtask : writeByte
	task automatic readByte(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitIo(1'b1, 1'b0, d[i]);
		bitIo(1'b1, 1'b0, s);
	endtask : readByte
	task automatic busStop();
		sdaLow = 1'b1;
		waitQ(QTR);
		sclLow = 1'b0;
		waitQ(QTR);
		sdaLow = 1'b0;
		waitQ(QTR);
	endtask : busStop
endmodule : dsc_bus_master
`default_nettype wire

// ==== verilog/dsc_pkg.sv ====
// Shared constants and types for the deflection serial control and sync block
package dsc_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] GLITCH_LIM = 4'(GLITCH_CYC - 1);
	localparam logic [6:0] DEV_ADDR = 7'h46;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam int NUM_ADJ = 16;
	localparam logic [3:0] SUB_HDRIVE = 4'h0;
	localparam logic [3:0] SUB_XRAY = 4'h1;
	localparam logic [3:0] SUB_PRIO = 4'h3;
	localparam logic [3:0] SUB_REFRESH = 4'h4;
	localparam int HDRIVE_BIT = 6;
	localparam int XRAYRST_BIT = 7;
	localparam int REFRESH_BIT = 7;
	localparam int PRIO_HI = 7;
	localparam int PRIO_LO = 6;
	localparam logic [1:0] PRIO_SEPARATE = 2'h3;
	localparam logic [1:0] PRIO_COMPOSITE = 2'h1;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [NUM_ADJ-1:0][7:0] ADJ_RESET = {
		8'h20, 8'ha0, 8'ha0, 8'h00, 8'h40, 8'ha0, 8'hc0, 8'h20,
		8'h20, 8'h40, 8'hc0, 8'h10, 8'hc0, 8'h00, 8'h40, 8'h40};
	typedef struct packed {
		logic hLockN;
		logic vLockN;
		logic xray;
		logic hPolNeg;
		logic vPolNeg;
		logic vExtDet;
		logic hvDet;
		logic vDet;
	} dsc_status_s;
	typedef struct packed {
		logic hPolNeg;
		logic vPolNeg;
		logic vExtDet;
		logic hvDet;
		logic vDet;
	} dsc_syncstat_s;
	localparam dsc_syncstat_s SYNCSTAT_RESET = 5'h18;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_SUB = 3'b010,
		PH_DATA = 3'b011,
		PH_READ = 3'b100,
		PH_IGNORE = 3'b101
	} dsc_phase_e;
endpackage : dsc_pkg

// ==== verilog/dsc_sync_ctrl.sv ====
// Serial control port, adjustment registers and sync identification of the deflection controller
//
// Notes on behaviour
// - First byte: 7-bit address plus direction bit
// - Direction zero writes, one reads
// - Write: subaddress byte, then data byte
// - Extra data bytes auto-increment the subaddress
// - Sixteen writable adjustment values by subaddress
// - Five control bits inside the adjustment bytes
// - Read returns exactly one reply byte
// - Reply holds lock, X-ray, polarity, detection
// - Lock flags one when unlocked; X-ray one active
// - Polarity resets negative; detection flags reset zero
// - Stop ends decoding and releases both lines
// - Bus glitches to 50 ns filtered; 400 kHz max
// - New adjustment outputs applied only at vertical retrace; priority, X-ray reset and refresh bits act at once
// - Main supply low inhibits lock, drive and both sync outputs
// - Logic supply below threshold holds initial values
// - X-ray latch cleared by supply drop or bit
// - Separate or composite sync chosen by priority bits
// - Vertical out needs priority written and supply
// - Lock output high while horizontal loop locked
// - Horizontal pulse under quarter period; leading edge
// - Composite wide pulses give vertical; equalizers removed
`timescale 1ns/1ps
`default_nettype none
module dsc_sync_ctrl #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic syncClk,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic vddOk,
	input wire logic vccOk,
	input wire logic xrayIn,
	input wire logic hPllLocked,
	input wire logic vLocked,
	input wire logic horizSyncInput,
	input wire logic vSyncIn,
	output logic hLockOut,
	output logic hDriveEn,
	output logic hSyncOut,
	output logic vSyncOut,
	output logic [dsc_pkg::NUM_ADJ-1:0][7:0] adjOut
);
	logic vddA, vddS, vccA, vccS, xrA, xrS, hlA, hlS, vlA, vlS;
	logic locRst;
	logic sclF, sdaF, sclPrev, sdaPrev, sclRise, sclFall, startCond, stopCond;
	dsc_pkg::dsc_phase_e phase_reg, pend_reg;
	logic [3:0] bitCnt_reg, subAddr_reg;
	logic [7:0] shift_reg, tx_reg;
	logic [dsc_pkg::NUM_ADJ-1:0][7:0] shadow_reg, active_reg;
	logic xrayLatch_reg, prioWritten_reg, refreshTgl_reg, retrTgl_reg;
	logic wrStrobe;
	logic [2:0] retrSync;
	logic retracePulse;
	dsc_pkg::dsc_syncstat_s stA, stS, syncStat_reg;
	dsc_pkg::dsc_status_s status;
	logic addrMatch;

	// The device never stretches the clock, so its clock pin is released for good
	assign sclOut = 1'b0;
	assign sclOe = 1'b0;
	assign sdaOut = 1'b0;

	// Pin synchronisers; supply monitors use rst_n only so they can reset the rest
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			{vddA, vddS, vccA, vccS} <= 4'h0;
			{xrA, xrS, hlA, hlS, vlA, vlS} <= 6'h00;
			{stA, stS} <= {dsc_pkg::SYNCSTAT_RESET, dsc_pkg::SYNCSTAT_RESET};
		end
		else
		begin
			{vddA, vddS, vccA, vccS} <= {vddOk, vddA, vccOk, vccA};
			{xrA, xrS, hlA, hlS, vlA, vlS} <= {xrayIn, xrA, hPllLocked, hlA, vLocked, vlA};
			stA <= syncStat_reg;
			stS <= stA;
		end
	end
	assign locRst = !rst_n || !vddS;

	// Each bus line must hold a new level for the full filter time before it is believed
	for (genvar i = 0; i < 2; i++)
	begin : g_busFilt
		logic syncA, syncB, filt;
		logic [3:0] cnt;
		always_ff @(posedge ref_clk)
		begin
			if (!rst_n)
			begin
				syncA <= 1'b1;
				syncB <= 1'b1;
				filt <= 1'b1;
				cnt <= 4'h0;
			end
			else
			begin
				syncA <= (i == 0) ? sdaIn : sclIn;
				syncB <= syncA;
				if (syncB == filt)
					cnt <= 4'h0;
				else if (cnt == dsc_pkg::GLITCH_LIM)
				begin
					filt <= syncB;
					cnt <= 4'h0;
				end
				else
					cnt <= cnt + 4'h1;
			end
		end
	end
	assign sdaF = g_busFilt[0].filt;
	assign sclF = g_busFilt[1].filt;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclPrev <= sclF;
			sdaPrev <= sdaF;
		end
	end
	assign sclRise = sclF && !sclPrev;
	assign sclFall = !sclF && sclPrev;
	assign startCond = sclF && sclPrev && !sdaF && sdaPrev;
	assign stopCond = sclF && sclPrev && sdaF && !sdaPrev;
	assign addrMatch = shift_reg[7:1] == dsc_pkg::DEV_ADDR;
	assign wrStrobe = sclFall && phase_reg == dsc_pkg::PH_DATA && bitCnt_reg == dsc_pkg::BIT_LAST;

	// Byte engine: bits sampled on rising clock, data line changed on falling clock
	always_ff @(posedge ref_clk)
	begin
		if (locRst || stopCond)
		begin
			phase_reg <= dsc_pkg::PH_IDLE;
			pend_reg <= dsc_pkg::PH_IDLE;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			sdaOe <= 1'b0;
		end
		else if (startCond)
		begin
			// The clock fall right after a start is no bit; parking in the ack slot absorbs it
			phase_reg <= dsc_pkg::PH_ADDR;
			pend_reg <= dsc_pkg::PH_ADDR;
			bitCnt_reg <= dsc_pkg::BIT_ACK;
			sdaOe <= 1'b0;
		end
		else if (sclRise && phase_reg != dsc_pkg::PH_IDLE && phase_reg != dsc_pkg::PH_IGNORE)
		begin
			if (bitCnt_reg != dsc_pkg::BIT_ACK)
				shift_reg <= {shift_reg[6:0], sdaF};
			else if (phase_reg == dsc_pkg::PH_READ)
				phase_reg <= dsc_pkg::PH_IGNORE;
		end
		else if (sclFall && phase_reg != dsc_pkg::PH_IDLE && phase_reg != dsc_pkg::PH_IGNORE)
		begin
			if (phase_reg == dsc_pkg::PH_READ)
			begin
				if (bitCnt_reg == dsc_pkg::BIT_LAST)
				begin
					sdaOe <= 1'b0;
					bitCnt_reg <= dsc_pkg::BIT_ACK;
				end
				else if (bitCnt_reg != dsc_pkg::BIT_ACK)
				begin
					tx_reg <= {tx_reg[6:0], 1'b0};
					sdaOe <= !tx_reg[6];
					bitCnt_reg <= bitCnt_reg + 4'h1;
				end
			end
			else if (bitCnt_reg == dsc_pkg::BIT_LAST)
			begin
				bitCnt_reg <= dsc_pkg::BIT_ACK;
				case (phase_reg)
					dsc_pkg::PH_ADDR:
					begin
						sdaOe <= addrMatch;
						if (!addrMatch)
							pend_reg <= dsc_pkg::PH_IGNORE;
						else if (shift_reg[0] == dsc_pkg::DIR_READ)
							pend_reg <= dsc_pkg::PH_READ;
						else
							pend_reg <= dsc_pkg::PH_SUB;
					end
					default:
					begin
						sdaOe <= 1'b1;
						pend_reg <= dsc_pkg::PH_DATA;
					end
				endcase
			end
			else if (bitCnt_reg == dsc_pkg::BIT_ACK)
			begin
				bitCnt_reg <= 4'h0;
				phase_reg <= pend_reg;
				if (pend_reg == dsc_pkg::PH_READ)
				begin
					tx_reg <= status;
					sdaOe <= !status[7];
				end
				else
					sdaOe <= 1'b0;
			end
			else
				bitCnt_reg <= bitCnt_reg + 4'h1;
		end
	end

	// Subaddress counter
	always_ff @(posedge ref_clk)
	begin
		if (locRst)
			subAddr_reg <= 4'h0;
		else if (sclFall && phase_reg == dsc_pkg::PH_SUB && bitCnt_reg == dsc_pkg::BIT_LAST)
			subAddr_reg <= shift_reg[3:0];
		else if (wrStrobe)
			subAddr_reg <= subAddr_reg + 4'h1;
	end

	// Received bytes land in the shadow set; control bits sit in the upper bits
	always_ff @(posedge ref_clk)
	begin
		if (locRst)
			shadow_reg <= dsc_pkg::ADJ_RESET;
		else if (wrStrobe)
			shadow_reg[subAddr_reg] <= shift_reg;
	end

	// Copying at retrace keeps the picture from jumping mid-field
	always_ff @(posedge ref_clk)
	begin
		if (locRst)
			active_reg <= dsc_pkg::ADJ_RESET;
		else if (retracePulse)
			active_reg <= shadow_reg;
	end
	assign adjOut = active_reg;

	always_ff @(posedge ref_clk)
	begin
		if (locRst)
		begin
			prioWritten_reg <= 1'b0;
			refreshTgl_reg <= 1'b0;
		end
		else if (wrStrobe)
		begin
			if (subAddr_reg == dsc_pkg::SUB_PRIO)
				prioWritten_reg <= 1'b1;
			if (subAddr_reg == dsc_pkg::SUB_REFRESH && shift_reg[dsc_pkg::REFRESH_BIT])
				refreshTgl_reg <= !refreshTgl_reg;
		end
	end

	// Supply drop clears the latch; otherwise a new hit wins over the software reset bit
	always_ff @(posedge ref_clk)
	begin
		if (locRst || !vccS)
			xrayLatch_reg <= 1'b0;
		else if (xrS)
			xrayLatch_reg <= 1'b1;
		else if (shadow_reg[dsc_pkg::SUB_XRAY][dsc_pkg::XRAYRST_BIT])
			xrayLatch_reg <= 1'b0;
	end

	assign status = {!hlS, !vlS, xrayLatch_reg, stS};

	always_ff @(posedge ref_clk)
	begin
		if (locRst)
		begin
			hLockOut <= 1'b0;
			hDriveEn <= 1'b0;
			retrSync <= 3'h0;
		end
		else
		begin
			hLockOut <= hlS && vccS;
			hDriveEn <= vccS && !xrayLatch_reg && active_reg[dsc_pkg::SUB_HDRIVE][dsc_pkg::HDRIVE_BIT];
			retrSync <= {retrSync[1:0], retrTgl_reg};
		end
	end
	assign retracePulse = retrSync[2] ^ retrSync[1];

	// Sync clock domain
	logic sRstA, sRstB, sVddA, sVddB, sVccA, sVccB, sPwA, sPwB, sRfA, sRfB, sRfPrev;
	logic [1:0] sPrA, sPrB;
	logic hRawA, hRawB, hPrev, vRawA, vRawB, vPrev, hNormPrev, vSelPrev, vExtr_reg;
	logic syncRst, hRise, hNorm, hLead, vSel, refreshEv;
	logic [CNT_W-1:0] rawCnt_reg, rawHigh_reg, sinceAcc_reg, lineP_reg, vBal_reg, pulseW;
	logic [CNT_W+1:0] pulseW4, rawCnt4, since4, line3;
	logic negNow;

	always_ff @(posedge syncClk)
	begin
		{sRstA, sRstB, sVddA, sVddB, sVccA, sVccB} <= {rst_n, sRstA, vddOk, sVddA, vccOk, sVccA};
		{sPwA, sPwB, sRfA, sRfB, sRfPrev} <= {prioWritten_reg, sPwA, refreshTgl_reg, sRfA, sRfB};
		sPrA <= shadow_reg[dsc_pkg::SUB_PRIO][dsc_pkg::PRIO_HI:dsc_pkg::PRIO_LO];
		sPrB <= sPrA;
		{hRawA, hRawB, vRawA, vRawB} <= {horizSyncInput, hRawA, vSyncIn, vRawA};
	end
	assign syncRst = !sRstB || !sVddB;
	assign refreshEv = sRfB ^ sRfPrev;
	assign hRise = hRawB && !hPrev;
	assign negNow = {rawHigh_reg, 1'b0} > {1'b0, rawCnt_reg};
	assign pulseW = negNow ? rawCnt_reg - rawHigh_reg : rawHigh_reg;
	assign pulseW4 = {pulseW, 2'b00};
	assign rawCnt4 = {2'b00, rawCnt_reg};
	assign hNorm = hRawB ^ syncStat_reg.hPolNeg;
	assign since4 = {sinceAcc_reg, 2'b00};
	assign line3 = {2'b00, lineP_reg} + {1'b0, lineP_reg, 1'b0};
	assign hLead = hNorm && !hNormPrev && since4 > line3;
	always_comb
	begin
		case (sPrB)
			dsc_pkg::PRIO_SEPARATE: vSel = vRawB ^ syncStat_reg.vPolNeg;
			dsc_pkg::PRIO_COMPOSITE: vSel = vExtr_reg;
			default: vSel = 1'b0;
		endcase
	end

	// Line measurement: period and high time between raw rising edges
	always_ff @(posedge syncClk)
	begin
		if (syncRst)
		begin
			// Raw edge detectors start from the present pin level, the normalised ones high, so leaving reset makes no false edge
			{hPrev, vPrev} <= {hRawB, vRawB};
			{hNormPrev, vSelPrev, vExtr_reg} <= 3'h6;
			rawCnt_reg <= '0;
			rawHigh_reg <= '0;
			sinceAcc_reg <= '0;
			lineP_reg <= '0;
		end
		else
		begin
			{hPrev, vPrev, hNormPrev, vSelPrev} <= {hRawB, vRawB, hNorm, vSel};
			rawCnt_reg <= hRise ? '0 : (&rawCnt_reg ? rawCnt_reg : rawCnt_reg + 1'b1);
			rawHigh_reg <= hRise ? '0 : (hRawB && !(&rawHigh_reg) ? rawHigh_reg + 1'b1 : rawHigh_reg);
			if (hRise)
				vExtr_reg <= pulseW4 > rawCnt4;
			if (hLead)
			begin
				// A saturated count means the old period is unknown, so the next edge is taken
				lineP_reg <= (&sinceAcc_reg) ? '0 : sinceAcc_reg;
				sinceAcc_reg <= '0;
			end
			else if (!(&sinceAcc_reg))
				sinceAcc_reg <= sinceAcc_reg + 1'b1;
		end
	end

	// Vertical polarity from which level dominates; mid-scale start reads negative
	always_ff @(posedge syncClk)
	begin
		if (syncRst)
			vBal_reg <= {1'b1, {(CNT_W-1){1'b0}}};
		else if (vRawB && !(&vBal_reg))
			vBal_reg <= vBal_reg + 1'b1;
		else if (!vRawB && vBal_reg != '0)
			vBal_reg <= vBal_reg - 1'b1;
	end

	// Detection flags: a detection in the refresh cycle survives it
	always_ff @(posedge syncClk)
	begin
		if (syncRst)
			syncStat_reg <= dsc_pkg::SYNCSTAT_RESET;
		else
		begin
			syncStat_reg.vPolNeg <= vBal_reg[CNT_W-1];
			if (hRise)
				syncStat_reg.hPolNeg <= negNow;
			if (vRawB != vPrev)
				syncStat_reg.vExtDet <= 1'b1;
			else if (refreshEv)
				syncStat_reg.vExtDet <= 1'b0;
			if (hRise && rawCnt_reg != '0 && pulseW4 < rawCnt4)
				syncStat_reg.hvDet <= 1'b1;
			else if (refreshEv)
				syncStat_reg.hvDet <= 1'b0;
			if (hRise && pulseW4 > rawCnt4)
				syncStat_reg.vDet <= 1'b1;
			else if (refreshEv)
				syncStat_reg.vDet <= 1'b0;
		end
	end

	always_ff @(posedge syncClk)
	begin
		if (syncRst)
		begin
			hSyncOut <= 1'b0;
			vSyncOut <= 1'b0;
			retrTgl_reg <= 1'b0;
		end
		else
		begin
			hSyncOut <= hLead && sVccB;
			vSyncOut <= vSel && sPwB && sVccB;
			if (vSel && !vSelPrev)
				retrTgl_reg <= !retrTgl_reg;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	stop_release_a: assert property (stopCond |=> !sdaOe && phase_reg == dsc_pkg::PH_IDLE)
		else $error("stop did not release data line");
	addr_nack_a: assert property (sclFall && phase_reg == dsc_pkg::PH_ADDR && bitCnt_reg == dsc_pkg::BIT_LAST
		&& !addrMatch && !stopCond && !startCond && vddS |=> !sdaOe)
		else $error("foreign address acknowledged");
	read_dir_a: assert property (sclFall && phase_reg == dsc_pkg::PH_ADDR && bitCnt_reg == dsc_pkg::BIT_LAST
		&& addrMatch && shift_reg[0] && !stopCond && !startCond && vddS |=> pend_reg == dsc_pkg::PH_READ)
		else $error("read direction not taken");
	auto_inc_a: assert property (wrStrobe && !stopCond && !startCond && vddS
		|=> subAddr_reg == $past(subAddr_reg) + 4'h1 && shadow_reg[$past(subAddr_reg)] == $past(shift_reg))
		else $error("auto increment write failed");
	retrace_only_a: assert property (!retracePulse && !locRst |=> $stable(active_reg))
		else $error("adjustment applied outside retrace");
	vcc_inhibit_a: assert property (!vccS ##1 !vccS |=> !hDriveEn && !hLockOut)
		else $error("outputs live with supply low");
	vdd_hold_a: assert property (!vddS |=> shadow_reg == dsc_pkg::ADJ_RESET && active_reg == dsc_pkg::ADJ_RESET)
		else $error("registers not held at initial values");
	xray_hold_a: assert property (xrayLatch_reg && vccS && vddS
		&& !shadow_reg[dsc_pkg::SUB_XRAY][dsc_pkg::XRAYRST_BIT] |=> xrayLatch_reg)
		else $error("xray latch dropped");
	lock_flag_a: assert property (sclFall && phase_reg == dsc_pkg::PH_ADDR && bitCnt_reg == dsc_pkg::BIT_ACK
		&& pend_reg == dsc_pkg::PH_READ && !stopCond && !startCond && vddS
		|=> tx_reg[7:6] == ~{$past(hlS), $past(vlS)})
		else $error("lock flags wrong sense");
	hlock_out_a: assert property ((hlS && vccS && vddS) [*2] |=> hLockOut)
		else $error("lock output low while locked");

	read_done_c: cover property (phase_reg == dsc_pkg::PH_READ ##1 phase_reg == dsc_pkg::PH_IGNORE);
	burst_write_c: cover property (wrStrobe && subAddr_reg == 4'hf ##1 subAddr_reg == 4'h0);
	retrace_copy_c: cover property (retracePulse && shadow_reg != active_reg);
endmodule : dsc_sync_ctrl
`default_nettype wire
